// file: design/bu_defs.vh
`ifndef BU_DEFS_VH
`define BU_DEFS_VH
// ==========================================================
// register byte offsets on the apb slave
`define BU_OFS_CMD      12'h000
`define BU_OFS_STAT     12'h004
`define BU_OFS_STATUS_FLAGS_REGISTER     12'h008
`define BU_OFS_CTRL     12'h00C
`define BU_PAGE_GPR     4'h1
`define BU_PAGE_IO      4'h2
// ==========================================================
// command word fields
`define BU_CMD_OP_HI    4
`define BU_CMD_OP_LO    0
`define BU_CMD_RD_HI    12
`define BU_CMD_RD_LO    8
`define BU_CMD_BIT_HI   18
`define BU_CMD_BIT_LO   16
`define BU_CMD_IO_HI    22
`define BU_CMD_IO_LO    20
// ==========================================================
// status word fields and control bits
`define BU_STAT_BUSY    0
`define BU_STAT_HALT    1
`define BU_STAT_SP_LO   8
`define BU_CTRL_RESUME  0
`define BU_STATUS_FLAGS_REGISTER_RESET   8'h00
`define BU_CMD_RESET    32'h0000_0000
// ==========================================================
// status flag positions
`define BU_F_C          3'h0
`define BU_F_Z          3'h1
`define BU_F_N          3'h2
`define BU_F_V          3'h3
`define BU_F_S          3'h4
`define BU_F_H          3'h5
`define BU_F_T          3'h6
`define BU_F_I          3'h7
// ==========================================================
// operation codes
`define BU_OP_NOP       5'h00
`define BU_OP_PUSH      5'h01
`define BU_OP_POP       5'h02
`define BU_OP_IOSET     5'h03
`define BU_OP_IOCLR     5'h04
`define BU_OP_LSL       5'h05
`define BU_OP_LSR       5'h06
`define BU_OP_ROL       5'h07
`define BU_OP_ROR       5'h08
`define BU_OP_ASR       5'h09
`define BU_OP_SWAP      5'h0A
`define BU_OP_FSET      5'h0B
`define BU_OP_FCLR      5'h0C
`define BU_OP_BST       5'h0D
`define BU_OP_BLD       5'h0E
`define BU_OP_SLEEP     5'h0F
`define BU_OP_WDR       5'h10
`define BU_OP_BREAK     5'h11
`define BU_OP_VSET      5'h12
`define BU_OP_VCLR      5'h13
`define BU_OP_HSET      5'h14
`define BU_OP_HCLR      5'h15
`define BU_OP_SSET      5'h16
`define BU_OP_SCLR      5'h17
`define BU_OP_ZSET      5'h18
`define BU_OP_ZCLR      5'h19
`define BU_OP_LAST      5'h19
// ==========================================================
// execution cycle counts
`define BU_CYC_TWO      2'd2
`define BU_CYC_ONE      2'd1
`endif

// file: design/bu_shift.v
`include "bu_defs.vh"
// ==========================================================
// shift, rotate and nibble exchange datapath
module bu_shift (
   op,
   a,
   c_in,
   res,
   c_out,
   z_out,
   n_out,
   v_out
);
   input  wire [4:0] op;
   input  wire [7:0] a;
   input  wire       c_in;
   output reg  [7:0] res;
   output reg        c_out;
   output wire       z_out;
   output wire       n_out;
   output wire       v_out;

   // ==========================================================
   // result and carry per operation
   always @* begin
      res   = a;
      c_out = c_in;
      case (op)
         `BU_OP_LSL: begin
            res   = {a[6:0], 1'b0};
            c_out = a[7];
         end
         `BU_OP_LSR: begin
            res   = {1'b0, a[7:1]};
            c_out = a[0];
         end
         `BU_OP_ROL: begin
            res   = {a[6:0], c_in};
            c_out = a[7];
         end
         `BU_OP_ROR: begin
            res   = {c_in, a[7:1]};
            c_out = a[0];
         end
         `BU_OP_ASR: begin
            res   = {a[7], a[7:1]};
            c_out = a[0];
         end
         `BU_OP_SWAP: res = {a[3:0], a[7:4]};
         default: res = a;
      endcase
   end

   // flags of the shifted value; overflow is sign xor carry
   assign z_out = (res == 8'h00);
   assign n_out = res[7];
   assign v_out = res[7] ^ c_out;
endmodule

// file: design/bu_core.v
// Operation
// - push copies the chosen register onto the stack in two cycles, flags untouched.
// - pop loads the chosen register from the stack in two cycles, flags untouched.
// - io bit set and clear force one bit of an io register in two cycles, flags untouched.
// - rotate left through carry takes old carry into bit 0 and bit 7 into carry in one cycle.
// - rotate right through carry takes old carry into bit 7 and bit 0 into carry in one cycle.
// - bit store copies a register bit into the transfer flag only, in one cycle.
// - bit load writes the transfer flag into a register bit in one cycle, flags untouched.
// - dedicated one-cycle ops raise or drop the overflow flag and nothing else.
// - dedicated one-cycle ops raise or drop the half-carry flag and nothing else.
// - dedicated one-cycle ops raise or drop the signed-test flag and nothing else.
// - dedicated one-cycle ops raise or drop the zero flag and nothing else.
// - break serves only debug, has no normal cycle count and changes no flag.
// - watchdog restart takes one cycle, changes no flag and signals the watchdog.
// - sleep takes one cycle, changes no flag and requests sleep from power control.
//
// Decided for this implementation: register access over APB and the register offsets.
`include "bu_defs.vh"
module bu_core #(
   parameter STACK_AW = 4
) (
   clock,
   reset,
   ce,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   sleep_req,
   wdt_restart,
   debug_break
);
   input  wire        clock;
   input  wire        reset;
   input  wire        ce;
   input  wire        psel;
   input  wire        penable;
   input  wire        pwrite;
   input  wire [11:0] paddr;
   input  wire [31:0] pwdata;
   output wire [31:0] prdata;
   output wire        pready;
   output wire        pslverr;
   output wire        sleep_req;
   output wire        wdt_restart;
   output wire        debug_break;

   // stack depth follows the pointer width; no overflow flag is kept
   localparam DEPTH = 1 << STACK_AW;
   // one-hot execution states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_EXEC = 3'b010;
   localparam [2:0] ST_HALT = 3'b100;

   // ==========================================================
   // storage
   reg  [7:0]          gpr [0:31];
   reg  [7:0]          iob [0:7];
   reg  [7:0]          stk [0:DEPTH-1];
   reg  [7:0]          status_flags_register_q;
   reg  [STACK_AW-1:0] sp_q;
   reg  [31:0]         cmd_q;
   reg  [2:0]          state_q;
   reg  [1:0]          cnt_q;
   reg  [31:0]         prdata_q;
   reg                 pready_q;
   reg                 pslverr_q;
   reg                 sleep_q;
   reg                 wdr_q;
   reg                 brk_q;
   integer             i;

   // fields of the held command, and the op field of an incoming write
   wire [4:0] op_q  = cmd_q[`BU_CMD_OP_HI:`BU_CMD_OP_LO];
   wire [4:0] rd_q  = cmd_q[`BU_CMD_RD_HI:`BU_CMD_RD_LO];
   wire [2:0] bit_q = cmd_q[`BU_CMD_BIT_HI:`BU_CMD_BIT_LO];
   wire [2:0] io_q  = cmd_q[`BU_CMD_IO_HI:`BU_CMD_IO_LO];
   wire [4:0] op_w  = pwdata[`BU_CMD_OP_HI:`BU_CMD_OP_LO];

   // ==========================================================
   // helpers
   // stack and io bit ops take two cycles, the rest one
   function [1:0] cycles_of;
      input [4:0] op;
      begin
         case (op)
            `BU_OP_PUSH,
            `BU_OP_POP,
            `BU_OP_IOSET,
            `BU_OP_IOCLR: cycles_of = `BU_CYC_TWO;
            default: cycles_of = `BU_CYC_ONE;
         endcase
      end
   endfunction

   // flag position of the dedicated raise and drop ops
   function [2:0] flag_of;
      input [4:0] op;
      begin
         case (op)
            `BU_OP_VSET, `BU_OP_VCLR: flag_of = `BU_F_V;
            `BU_OP_HSET, `BU_OP_HCLR: flag_of = `BU_F_H;
            `BU_OP_SSET, `BU_OP_SCLR: flag_of = `BU_F_S;
            default: flag_of = `BU_F_Z;
         endcase
      end
   endfunction

   // true for a word-aligned address that holds a register
   function map_ok;
      input [11:0] a;
      begin
         if (a[1:0] != 2'b00)
            map_ok = 1'b0;
         else if (a[11:8] == `BU_PAGE_GPR)
            map_ok = (a[7] == 1'b0);
         else if (a[11:8] == `BU_PAGE_IO)
            map_ok = (a[7:5] == 3'b000);
         else
            map_ok = (a[11:4] == 8'h00);
      end
   endfunction

   // ==========================================================
   // shift datapath
   wire [7:0] sh_res;
   wire       sh_c;
   wire       sh_z;
   wire       sh_n;
   wire       sh_v;

   bu_shift u_shift (
      .op    (op_q),
      .a     (gpr[rd_q]),
      .c_in  (status_flags_register_q[`BU_F_C]),
      .res   (sh_res),
      .c_out (sh_c),
      .z_out (sh_z),
      .n_out (sh_n),
      .v_out (sh_v)
   );

   // ==========================================================
   // apb decode
   // one wait state keeps pready, prdata and pslverr registered
   wire acc     = psel & penable & pready_q;
   wire idle    = (state_q == ST_IDLE);
   wire commit  = (state_q == ST_EXEC) && (cnt_q == 2'd0);
   wire is_cmd  = (paddr == `BU_OFS_CMD);
   wire is_status_flags_register = (paddr == `BU_OFS_STATUS_FLAGS_REGISTER);
   wire is_ctrl = (paddr == `BU_OFS_CTRL);
   wire is_gpr  = (paddr[11:8] == `BU_PAGE_GPR);
   wire is_io   = (paddr[11:8] == `BU_PAGE_IO);

   // refuse bad addresses, unknown ops and state writes while running
   wire bad_op  = is_cmd & (op_w > `BU_OP_LAST);
   wire busy_wr = pwrite & ~idle & ~is_ctrl;
   wire err_d   = ~map_ok(paddr) | (pwrite & bad_op) | busy_wr;
   wire wr_ok   = acc & pwrite & ~pslverr_q;

   // read mux
   reg [31:0] rdata_d;
   always @* begin
      rdata_d = 32'h0000_0000;
      if (is_gpr)
         rdata_d = {24'h00_0000, gpr[paddr[6:2]]};
      else if (is_io)
         rdata_d = {24'h00_0000, iob[paddr[4:2]]};
      else if (is_cmd)
         rdata_d = cmd_q;
      else if (is_status_flags_register)
         rdata_d = {24'h00_0000, status_flags_register_q};
      else if (paddr == `BU_OFS_STAT) begin
         rdata_d[`BU_STAT_BUSY] = ~idle;
         rdata_d[`BU_STAT_HALT] = (state_q == ST_HALT);
         rdata_d[`BU_STAT_SP_LO +: STACK_AW] = sp_q;
      end
   end

   // ==========================================================
   // apb response registers
   always @(posedge clock) begin
      if (reset) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         pready_q  <= psel & penable & ~pready_q;
         if (psel & penable & ~pready_q) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr_q <= err_d;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // sequencer: accept command, count cycles, park on break
   always @(posedge clock) begin
      if (reset) begin
         state_q <= ST_IDLE;
         cnt_q   <= 2'd0;
         cmd_q   <= `BU_CMD_RESET;
      end else if (ce) begin
         case (state_q)
            ST_IDLE: begin
               // decode from pwdata: cmd_q only loads on this same edge
               if (wr_ok & is_cmd) begin
                  cmd_q   <= pwdata;
                  cnt_q   <= cycles_of(op_w) - 2'd1;
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (cnt_q != 2'd0)
                  cnt_q <= cnt_q - 2'd1;
               else if (op_q == `BU_OP_BREAK)
                  state_q <= ST_HALT;
               else
                  state_q <= ST_IDLE;
            end
            ST_HALT: begin
               // only software resumes; no cycle count applies here
               if (wr_ok & is_ctrl & pwdata[`BU_CTRL_RESUME])
                  state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // control pulses to watchdog and power logic, and the break request to the debugger
   // sleep and watchdog pulses one cycle wide with ce high; a low ce stretches them, as all state freezes
   always @(posedge clock) begin
      if (reset) begin
         sleep_q <= 1'b0;
         wdr_q   <= 1'b0;
         brk_q   <= 1'b0;
      end else if (ce) begin
         sleep_q <= commit & (op_q == `BU_OP_SLEEP);
         wdr_q   <= commit & (op_q == `BU_OP_WDR);
         // level while parked, so the debugger sees a steady request
         brk_q   <= (commit & (op_q == `BU_OP_BREAK)) |
                    ((state_q == ST_HALT) &
                     ~(wr_ok & is_ctrl & pwdata[`BU_CTRL_RESUME]));
      end
   end

   // ==========================================================
   // status flags, written by software when idle or by commit
   // software writes are refused while busy, so they never meet a commit
   always @(posedge clock) begin
      if (reset) begin
         status_flags_register_q <= `BU_STATUS_FLAGS_REGISTER_RESET;
      end else if (ce) begin
         if (wr_ok & is_status_flags_register) begin
            status_flags_register_q <= pwdata[7:0];
         end else if (commit) begin
            case (op_q)
               `BU_OP_LSL, `BU_OP_LSR, `BU_OP_ROL,
               `BU_OP_ROR, `BU_OP_ASR: begin
                  status_flags_register_q[`BU_F_C] <= sh_c;
                  status_flags_register_q[`BU_F_Z] <= sh_z;
                  status_flags_register_q[`BU_F_N] <= sh_n;
                  status_flags_register_q[`BU_F_V] <= sh_v;
               end
               `BU_OP_FSET: status_flags_register_q[bit_q] <= 1'b1;
               `BU_OP_FCLR: status_flags_register_q[bit_q] <= 1'b0;
               `BU_OP_BST: status_flags_register_q[`BU_F_T] <= gpr[rd_q][bit_q];
               `BU_OP_VSET, `BU_OP_VCLR: begin
                  status_flags_register_q[flag_of(op_q)] <= ~op_q[0];
               end
               `BU_OP_HSET, `BU_OP_HCLR: begin
                  status_flags_register_q[flag_of(op_q)] <= ~op_q[0];
               end
               `BU_OP_SSET, `BU_OP_SCLR: begin
                  status_flags_register_q[flag_of(op_q)] <= ~op_q[0];
               end
               `BU_OP_ZSET, `BU_OP_ZCLR: begin
                  status_flags_register_q[flag_of(op_q)] <= ~op_q[0];
               end
               default: status_flags_register_q <= status_flags_register_q;
            endcase
         end
      end
   end

   // ==========================================================
   // register file, io bank and stack
   // stack grows upward and wraps silently; software must track depth
   always @(posedge clock) begin
      if (reset) begin
         sp_q <= {STACK_AW{1'b0}};
         for (i = 0; i < 32; i = i + 1)
            gpr[i] <= 8'h00;
         for (i = 0; i < 8; i = i + 1)
            iob[i] <= 8'h00;
      end else if (ce) begin
         if (wr_ok & is_gpr) begin
            gpr[paddr[6:2]] <= pwdata[7:0];
         end else if (wr_ok & is_io) begin
            iob[paddr[4:2]] <= pwdata[7:0];
         end else if (commit) begin
            case (op_q)
               `BU_OP_PUSH: begin
                  stk[sp_q] <= gpr[rd_q];
                  sp_q      <= sp_q + 1'b1;
               end
               `BU_OP_POP: begin
                  gpr[rd_q] <= stk[sp_q - 1'b1];
                  sp_q      <= sp_q - 1'b1;
               end
               `BU_OP_IOSET: iob[io_q][bit_q] <= 1'b1;
               `BU_OP_IOCLR: iob[io_q][bit_q] <= 1'b0;
               `BU_OP_LSL, `BU_OP_LSR, `BU_OP_ROL,
               `BU_OP_ROR, `BU_OP_ASR: begin
                  gpr[rd_q] <= sh_res;
               end
               `BU_OP_SWAP: gpr[rd_q] <= sh_res;
               `BU_OP_BLD: gpr[rd_q][bit_q] <= status_flags_register_q[`BU_F_T];
               default: sp_q <= sp_q;
            endcase
         end
      end
   end

   // ==========================================================
   // outputs straight from flip-flops
   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign sleep_req   = sleep_q;
   assign wdt_restart = wdr_q;
   assign debug_break = brk_q;
endmodule

// file: testbench/bu_core_props.sv
`include "bu_defs.vh"
// ==========
// port checker; frozen cycles (ce low) are skipped
module bu_core_props #(
   parameter STACK_AW = 4
) (
   input wire        clock,
   input wire        reset,
   input wire        ce,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        sleep_req,
   input wire        wdt_restart,
   input wire        debug_break
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset || !ce);
   // accepted writes decoded once so each property stays short
   wire take   = psel && penable && pready && pwrite && !pslverr;
   wire cmd_ok = take && paddr == `BU_OFS_CMD;
   wire resume = take && paddr == `BU_OFS_CTRL && pwdata[0];
   wire slp_c  = cmd_ok && pwdata[4:0] == `BU_OP_SLEEP;
   wire wdr_c  = cmd_ok && pwdata[4:0] == `BU_OP_WDR;
   wire brk_c  = cmd_ok && pwdata[4:0] == `BU_OP_BREAK;
   // a taken sleep command still waiting for its pulse, across frozen cycles
   logic slp_pend;
   always @(posedge clock) begin
      if (reset)
         slp_pend <= 1'b0;
      else if (slp_c)
         slp_pend <= 1'b1;
      else if (sleep_req)
         slp_pend <= 1'b0;
   end
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("late ready");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready too long");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_sleep_time: assert property (slp_c |-> ##2 sleep_req ##1 !sleep_req)
      else $error("sleep pulse timing");
   a_sleep_cause: assert property ($rose(sleep_req) |-> slp_pend)
      else $error("stray sleep pulse");
   a_wdt_time: assert property (wdr_c |-> ##2 wdt_restart ##1 !wdt_restart)
      else $error("watchdog pulse timing");
   a_break_time: assert property (brk_c |-> ##2 debug_break)
      else $error("no halt");
   a_break_hold: assert property (debug_break && !resume |=> debug_break)
      else $error("halt dropped");
   a_break_clear: assert property (resume |=> !debug_break)
      else $error("halt kept");
   // main scenarios reached
   c_sleep: cover property (slp_c);
   c_wdr: cover property (wdr_c);
   c_halt: cover property (brk_c ##2 debug_break);
   c_err: cover property (pslverr);
endmodule
bind bu_core bu_core_props #(.STACK_AW(STACK_AW)) u_props (
   .clock(clock), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
   .wdt_restart(wdt_restart), .debug_break(debug_break));

// file: testbench/bu_prog_mem.sv
// ==========
// program memory: fixed command words for the hand-written cases
module bu_prog_mem (
   input  wire logic [4:0]  pc,
   output      logic [31:0] word
);
   timeunit 1ns;
   timeprecision 1ps;
   // one word a step; unknown steps read as nop
   always_comb begin
      case (pc)
         5'h00: word = 32'h0000_0501; // push r5
         5'h01: word = 32'h0000_0602; // pop r6
         5'h02: word = 32'h0025_0003; // io 2 bit 5 high
         5'h03: word = 32'h0025_0004; // io 2 bit 5 low
         5'h04: word = 32'h0000_0011; // break
         5'h05: word = 32'h0000_001A; // past the last code
         default: word = 32'h0000_0000;
      endcase
   end
endmodule

// file: testbench/tb.sv
`include "bu_defs.vh"
// ==========
// bench for the bit and flag unit
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock;
   logic        reset;
   logic        ce;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         sleep_req;
   wire         wdt_restart;
   wire         debug_break;
   logic [4:0]  pc;
   wire  [31:0] pm_word;
   logic [31:0] rd;
   logic        er;
   logic [43:0] r;
   int          failures = 0;
   int          check_count = 0;
   int          cyc = 0;
   int          n_sleep = 0;
   int          n_wdt = 0;
   // op, bit, reg in, flags in, reg out, flags out
   logic [43:0] rows [21] = '{
      44'h05_0_81_F0_02_F9, 44'h06_0_01_00_00_0B,
      44'h07_0_80_01_01_09, 44'h08_0_01_01_80_05,
      44'h09_0_81_00_C0_05, 44'h0A_0_A5_FF_5A_FF,
      44'h0D_7_80_00_80_40, 44'h0E_0_80_40_81_40,
      44'h0B_7_00_00_00_80, 44'h0C_0_00_FF_00_FE,
      44'h12_0_00_00_00_08, 44'h13_0_00_FF_00_F7,
      44'h14_0_00_00_00_20, 44'h15_0_00_FF_00_DF,
      44'h16_0_00_00_00_10, 44'h17_0_00_FF_00_EF,
      44'h18_0_00_00_00_02, 44'h19_0_00_FF_00_FD,
      44'h00_0_3C_FF_3C_FF, 44'h0F_0_3C_A5_3C_A5,
      44'h10_0_3C_5A_3C_5A};
   // ce is dropped once around a sleep command to check the freeze
   bu_core #(.STACK_AW(4)) dut (
      .clock(clock), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
      .wdt_restart(wdt_restart), .debug_break(debug_break));
   bu_prog_mem pm (.pc(pc), .word(pm_word));
   // free running clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // pulse counts and hang guard
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (sleep_req === 1'b1) n_sleep <= n_sleep + 1;
      if (wdt_restart === 1'b1) n_wdt <= n_wdt + 1;
      if (cyc == 20000) begin
         failures++;
         stop_test();
      end
   end
   // one transfer; request held until ready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // issue a command, poll busy; commands must not overlap
   task automatic run(input logic [31:0] w);
      apb(1'b1, `BU_OFS_CMD, w);
      chk({31'h0, er}, 32'h0, "cmd refused");
      rd = 32'h1;
      while (rd[0] !== 1'b0) apb(1'b0, `BU_OFS_STAT, 32'h0);
   endtask
   task automatic fetch(input logic [4:0] i);
      pc = i;
      #1;
      run(pm_word);
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      reset = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pc = 5'h00;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      apb(1'b0, `BU_OFS_STATUS_FLAGS_REGISTER, 32'h0);
      chk(rd, 32'h0, "status_flags_register reset");
      apb(1'b0, `BU_OFS_STAT, 32'h0);
      chk(rd, 32'h0, "stat reset");
      $display("done reset");
      foreach (rows[i]) begin
         r = rows[i];
         apb(1'b1, 12'h10C, {24'h0, r[31:24]});
         apb(1'b1, `BU_OFS_STATUS_FLAGS_REGISTER, {24'h0, r[23:16]});
         run({13'h0, r[34:32], 8'h03, 3'h0, r[40:36]});
         apb(1'b0, 12'h10C, 32'h0);
         chk(rd, {24'h0, r[15:8]}, "reg");
         apb(1'b0, `BU_OFS_STATUS_FLAGS_REGISTER, 32'h0);
         chk(rd, {24'h0, r[7:0]}, "flags");
      end
      chk(n_sleep, 32'h1, "sleep pulses");
      chk(n_wdt, 32'h1, "wdr pulses");
      $display("done table");
      // a sleep taken just before ce drops must not fire until ce returns
      apb(1'b1, `BU_OFS_CMD, {27'h0, `BU_OP_SLEEP});
      ce <= 1'b0;
      repeat (4) @(posedge clock);
      chk(n_sleep, 32'h1, "frozen sleep");
      ce <= 1'b1;
      apb(1'b0, `BU_OFS_STAT, 32'h0);
      chk(rd, 32'h0, "thawed stat");
      chk(n_sleep, 32'h2, "thawed sleep");
      $display("done freeze");
      apb(1'b1, 12'h114, 32'h3C);
      apb(1'b1, `BU_OFS_STATUS_FLAGS_REGISTER, 32'hA5);
      fetch(5'h00);
      apb(1'b0, `BU_OFS_STAT, 32'h0);
      chk(rd, 32'h100, "sp");
      fetch(5'h01);
      apb(1'b0, 12'h118, 32'h0);
      chk(rd, 32'h3C, "pop");
      fetch(5'h02);
      apb(1'b0, 12'h208, 32'h0);
      chk(rd, 32'h20, "io set");
      fetch(5'h03);
      apb(1'b0, 12'h208, 32'h0);
      chk(rd, 32'h0, "io clr");
      apb(1'b0, `BU_OFS_STATUS_FLAGS_REGISTER, 32'h0);
      chk(rd, 32'hA5, "stack flags");
      $display("done stack");
      pc = 5'h05;
      #1;
      apb(1'b1, `BU_OFS_CMD, pm_word);
      chk({31'h0, er}, 32'h1, "bad op");
      apb(1'b0, 12'h300, 32'h0);
      chk(rd, 32'h0, "unmapped data");
      chk({31'h0, er}, 32'h1, "unmapped err");
      pc = 5'h04;
      #1;
      apb(1'b1, `BU_OFS_CMD, pm_word);
      repeat (3) @(posedge clock);
      chk({31'h0, debug_break}, 32'h1, "halt");
      apb(1'b1, 12'h114, 32'h0);
      chk({31'h0, er}, 32'h1, "halted write");
      apb(1'b0, `BU_OFS_STAT, 32'h0);
      chk(rd, 32'h3, "halted stat");
      apb(1'b1, `BU_OFS_CTRL, 32'h1);
      @(posedge clock);
      chk({31'h0, debug_break}, 32'h0, "resume");
      apb(1'b0, `BU_OFS_STATUS_FLAGS_REGISTER, 32'h0);
      chk(rd, 32'hA5, "break flags");
      apb(1'b0, `BU_OFS_CMD, 32'h0);
      chk(rd, 32'h11, "cmd readback");
      $display("done break");
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      apb(1'b0, `BU_OFS_STATUS_FLAGS_REGISTER, 32'h0);
      chk(rd, 32'h0, "status_flags_register rereset");
      $display("done rereset");
      stop_test();
   end
endmodule
